// File: rtl/port_fault_map.svh
// offsets, field positions, codes and timing counts for the port fault sequencer
`ifndef PORT_FAULT_MAP_SVH
`define PORT_FAULT_MAP_SVH
`define PF_CLK_NS 10
`define PF_T_DATA_SHORT_NS 20000
`define PF_T_DATA_LONG_NS 200000
`define PF_T_CC_SHORT_NS 20000
`define PF_T_CC_LONG_NS 200000
`define PF_T_SG_SHORT_NS 20000
`define PF_T_SG_LONG_NS 200000
`define PF_T_OT_REC_NS 20000
`define PF_T_BV_REC_NS 20000
`define PF_T_DEASSERT_NS 1000
`define PF_CYC(ns) (((ns) + `PF_CLK_NS - 1) / `PF_CLK_NS)
`define PF_CNT_W 24
`define PF_NUM_CH 5
`define PF_CH_DATA 0
`define PF_CH_CC 1
`define PF_CH_SG 2
`define PF_CH_OT 3
`define PF_CH_BV 4
`define PF_MASK_GND 2'h0
`define PF_MASK_OPEN 2'h1
`define PF_MASK_HIGH 2'h2
`define PF_REP_ALL 5'h1F
`define PF_REP_NO_BV 5'h0F
`define PF_REP_NO_OV 5'h1C
`define PF_OFS_CTRL 8'h00
`define PF_OFS_STATUS 8'h04
`define PF_OFS_SEEN 8'h08
`define PF_CTRL_RST 1'h0
`define PF_ST_CLOSED 8
`define PF_ST_FAULT 9
`define PF_ST_GATE 10
`define PF_ST_FLAG 11
`define PF_ST_MASK 12
`define PF_ST_SUPPLY 14
`define PF_RESP_OKAY 2'h0
`define PF_RESP_DECERR 2'h3
`endif

// File: rtl/port_fault_pkg.sv
// types shared by the port fault sequencer
package port_fault_pkg;
	typedef struct packed {
		logic dplus;
		logic dminus;
		logic cc1;
		logic cc2;
		logic vconn;
	} pass_sw_t;
	typedef struct packed {
		logic supply_ok;
		logic back_voltage;
		logic over_temperature_flag;
		logic ground_short_sense;
		logic connector_cfg_line2_ov;
		logic connector_cfg_line1_ov;
		logic data_ov;
	} cmp_in_t;
	typedef enum logic [1:0] {
		CH_IDLE = 2'b00,
		CH_SHORT = 2'b01,
		CH_LONG_WAIT = 2'b10,
		CH_LONG_REC = 2'b11
	} ch_state_t;
endpackage

// File: rtl/port_fault_sequencer.sv
// fault sequencer for a type-c port protector, with an axi4-lite register slave
//
// Summary of operation
// - data-line overvoltage opens all pass switches and asserts the fault output quickly.
// - cleared data overvoltage plus short recovery time closes switches, then releases fault.
// - data overvoltage still present at short timeout waits for clear plus long time.
// - fault output releases only after the deassert delay with switches closed.
// - either cc line overvoltage opens all switches and asserts the fault output.
// - cleared cc overvoltage plus short cc recovery closes switches, then releases fault.
// - cc overvoltage persisting past short recovery needs clear plus long cc time.
// - ground short sense high raises the ground short flag and drives gate low.
// - ground short opens all internal pass switches and asserts the fault output.
// - ground short cleared plus short recovery closes switches, gate high, fault later released.
// - ground short still present at short timeout keeps gate low, switches open.
// - persistent ground short cleared plus long recovery reconnects switches and gate.
// - over-temperature is a fault that opens the pass switches.
// - three report choices: all, all but back-voltage, all but overvoltage.
// - mask pin low reports all, open hides back-voltage, high hides overvoltage.
// - a suppressed fault still opens and restores switches like any other fault.
// - ground switch gate stays high during faults other than ground short.
`timescale 1ns/1ps
`include "port_fault_map.svh"

module pf_channel
	import port_fault_pkg::*;
#(
	parameter int unsigned SHORT_CYC = 16,
	parameter int unsigned LONG_CYC = 16
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// fault condition and status
	input wire logic cond,
	output logic busy
);
	ch_state_t state_ff;
	ch_state_t nxt_state;
	logic [`PF_CNT_W-1:0] cnt_ff;
	logic [`PF_CNT_W-1:0] nxt_cnt;
	logic cond_d_ff;
	wire cond_rise = cond & ~cond_d_ff;
	wire short_end = (cnt_ff == `PF_CNT_W'(SHORT_CYC - 1));
	wire long_end = (cnt_ff == `PF_CNT_W'(LONG_CYC - 1));
	wire [`PF_CNT_W-1:0] cnt_inc = cnt_ff + `PF_CNT_W'(1);

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		case (state_ff)
			CH_IDLE: begin
				nxt_cnt = '0;
				if (cond) begin
					nxt_state = CH_SHORT;
				end
			end
			CH_SHORT: begin
				if (cond_rise) begin
					nxt_cnt = '0;
				end else if (short_end) begin
					nxt_cnt = '0;
					nxt_state = cond ? CH_LONG_WAIT : CH_IDLE;
				end else begin
					nxt_cnt = cnt_inc;
				end
			end
			CH_LONG_WAIT: begin
				nxt_cnt = '0;
				if (!cond) begin
					nxt_state = CH_LONG_REC;
				end
			end
			CH_LONG_REC: begin
				if (cond) begin
					nxt_state = CH_LONG_WAIT;
					nxt_cnt = '0;
				end else if (long_end) begin
					nxt_state = CH_IDLE;
					nxt_cnt = '0;
				end else begin
					nxt_cnt = cnt_inc;
				end
			end
			default: begin
				nxt_state = CH_IDLE;
				nxt_cnt = '0;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= CH_IDLE;
			cnt_ff <= '0;
			cond_d_ff <= 1'b0;
			busy <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			cond_d_ff <= cond;
			busy <= (nxt_state != CH_IDLE);
		end
	end

	chk_long_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_ff == CH_LONG_WAIT && cond) |=> (state_ff == CH_LONG_WAIT))
		else $error("long wait left while fault present");
	chk_short_exit: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_ff == CH_SHORT && nxt_state == CH_IDLE) |-> short_end && !cond)
		else $error("short recovery ended early");
	chk_long_exit: assert property (@(posedge aclk) disable iff (!aresetn)
		($past(state_ff) == CH_LONG_REC && state_ff == CH_IDLE) |-> $past(long_end))
		else $error("long recovery ended early");
endmodule

module port_fault_sequencer
	import port_fault_pkg::*;
#(
	parameter int unsigned DATA_SHORT_CYC = `PF_CYC(`PF_T_DATA_SHORT_NS),
	parameter int unsigned DATA_LONG_CYC = `PF_CYC(`PF_T_DATA_LONG_NS),
	parameter int unsigned CC_SHORT_CYC = `PF_CYC(`PF_T_CC_SHORT_NS),
	parameter int unsigned CC_LONG_CYC = `PF_CYC(`PF_T_CC_LONG_NS),
	parameter int unsigned SG_SHORT_CYC = `PF_CYC(`PF_T_SG_SHORT_NS),
	parameter int unsigned SG_LONG_CYC = `PF_CYC(`PF_T_SG_LONG_NS),
	parameter int unsigned OT_REC_CYC = `PF_CYC(`PF_T_OT_REC_NS),
	parameter int unsigned BV_REC_CYC = `PF_CYC(`PF_T_BV_REC_NS),
	parameter int unsigned DEASSERT_CYC = `PF_CYC(`PF_T_DEASSERT_NS)
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// comparator and strap pins
	input wire cmp_in_t cmp_raw,
	input wire logic [1:0] fault_mask_select,
	// protection outputs
	output pass_sw_t pass_sw,
	output logic fault_n,
	output logic ground_switch_gate,
	output logic ground_short_flag
);
	localparam int unsigned SHORT_TAB [`PF_NUM_CH] =
		'{DATA_SHORT_CYC, CC_SHORT_CYC, SG_SHORT_CYC, OT_REC_CYC, BV_REC_CYC};
	localparam int unsigned LONG_TAB [`PF_NUM_CH] =
		'{DATA_LONG_CYC, CC_LONG_CYC, SG_LONG_CYC, OT_REC_CYC, BV_REC_CYC};

	// two-flop synchronisers for every pin input
	logic [8:0] meta_ff;
	logic [8:0] sync_ff;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= {fault_mask_select, cmp_raw};
			sync_ff <= meta_ff;
		end
	end
	wire cmp_in_t cmp_s = cmp_in_t'(sync_ff[6:0]);
	wire [1:0] mask_s = sync_ff[8:7];

	// fault channels
	wire [`PF_NUM_CH-1:0] ch_cond = {cmp_s.back_voltage, cmp_s.over_temperature_flag,
		cmp_s.ground_short_sense,
		cmp_s.connector_cfg_line1_ov | cmp_s.connector_cfg_line2_ov, cmp_s.data_ov};
	logic [`PF_NUM_CH-1:0] ch_busy;
	genvar gi;
	generate
		for (gi = 0; gi < `PF_NUM_CH; gi++) begin : g_ch
			pf_channel #(
				.SHORT_CYC(SHORT_TAB[gi]),
				.LONG_CYC(LONG_TAB[gi])
			) u_ch (
				.aclk(aclk),
				.aresetn(aresetn),
				.cond(ch_cond[gi] & cmp_s.supply_ok),
				.busy(ch_busy[gi])
			);
		end
	endgenerate

	// report selection; an undefined strap code falls back to reporting all
	wire [`PF_NUM_CH-1:0] rep_en = (mask_s == `PF_MASK_OPEN) ? `PF_REP_NO_BV :
		(mask_s == `PF_MASK_HIGH) ? `PF_REP_NO_OV : `PF_REP_ALL;
	wire rep_busy = |(ch_busy & rep_en);
	wire any_busy = |ch_busy;

	// software registers
	logic force_open_ff;
	logic [`PF_NUM_CH-1:0] seen_ff;
	logic [`PF_NUM_CH-1:0] busy_d_ff;

	// switch control: masked faults still open the switches
	wire sw_close = cmp_s.supply_ok & ~any_busy & ~force_open_ff;
	wire pass_sw_t nxt_pass_sw = sw_close ? pass_sw_t'('1) : pass_sw_t'('0);
	wire all_closed = (pass_sw == pass_sw_t'('1));

	// fault output release timer
	logic [`PF_CNT_W-1:0] dcnt_ff;
	wire dcnt_end = (dcnt_ff == `PF_CNT_W'(DEASSERT_CYC - 1));
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pass_sw <= pass_sw_t'('0);
			fault_n <= 1'b1;
			dcnt_ff <= '0;
			ground_switch_gate <= 1'b1;
			ground_short_flag <= 1'b0;
		end else begin
			pass_sw <= nxt_pass_sw;
			ground_short_flag <= cmp_s.ground_short_sense;
			ground_switch_gate <= ~ch_busy[`PF_CH_SG];
			if (rep_busy) begin
				fault_n <= 1'b0;
				dcnt_ff <= '0;
			end else if (!fault_n && all_closed) begin
				if (dcnt_end) begin
					fault_n <= 1'b1;
				end else begin
					dcnt_ff <= dcnt_ff + `PF_CNT_W'(1);
				end
			end else begin
				dcnt_ff <= '0;
			end
		end
	end

	// axi4-lite slave: one write and one read in flight
	logic aw_have_ff;
	logic w_have_ff;
	logic [7:0] awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	wire aw_hs = s_axi_awvalid & s_axi_awready;
	wire w_hs = s_axi_wvalid & s_axi_wready;
	wire b_hs = s_axi_bvalid & s_axi_bready;
	wire ar_hs = s_axi_arvalid & s_axi_arready;
	wire r_hs = s_axi_rvalid & s_axi_rready;
	wire wr_do = aw_have_ff & w_have_ff & ~s_axi_bvalid;
	wire [7:0] wr_word = {awaddr_ff[7:2], 2'b00};
	wire [7:0] rd_word = {s_axi_araddr[7:2], 2'b00};
	wire wr_hit_ctrl = (wr_word == `PF_OFS_CTRL);
	wire wr_hit_seen = (wr_word == `PF_OFS_SEEN);
	wire wr_ok = wr_hit_ctrl | wr_hit_seen | (wr_word == `PF_OFS_STATUS);
	wire wr_ctrl = wr_do & wr_hit_ctrl & wstrb_ff[0];
	wire [`PF_NUM_CH-1:0] seen_clr = (wr_do & wr_hit_seen & wstrb_ff[0]) ?
		wdata_ff[`PF_NUM_CH-1:0] : '0;
	// set wins over a write-one-to-clear in the same cycle
	wire [`PF_NUM_CH-1:0] seen_set = ch_busy & ~busy_d_ff;
	wire [`PF_NUM_CH-1:0] nxt_seen = (seen_ff & ~seen_clr) | seen_set;

	wire [31:0] status_word = {17'h0, cmp_s.supply_ok, mask_s, ground_short_flag,
		ground_switch_gate, ~fault_n, all_closed, 3'h0, ch_busy};
	wire rd_hit_ctrl = (rd_word == `PF_OFS_CTRL);
	wire rd_hit_status = (rd_word == `PF_OFS_STATUS);
	wire rd_hit_seen = (rd_word == `PF_OFS_SEEN);
	wire rd_ok = rd_hit_ctrl | rd_hit_status | rd_hit_seen;
	wire [31:0] rd_mux = rd_hit_ctrl ? {31'h0, force_open_ff} :
		rd_hit_status ? status_word :
		rd_hit_seen ? {27'h0, seen_ff} : 32'h0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			force_open_ff <= `PF_CTRL_RST;
			seen_ff <= '0;
			busy_d_ff <= '0;
		end else begin
			busy_d_ff <= ch_busy;
			seen_ff <= nxt_seen;
			if (wr_ctrl) begin
				force_open_ff <= wdata_ff[0];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			aw_have_ff <= 1'b0;
			w_have_ff <= 1'b0;
			awaddr_ff <= '0;
			wdata_ff <= '0;
			wstrb_ff <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `PF_RESP_OKAY;
		end else begin
			if (aw_hs) begin
				aw_have_ff <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (w_hs) begin
				w_have_ff <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_do) begin
				aw_have_ff <= 1'b0;
				w_have_ff <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? `PF_RESP_OKAY : `PF_RESP_DECERR;
			end
			if (b_hs) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= `PF_RESP_OKAY;
		end else if (ar_hs) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_mux;
			s_axi_rresp <= rd_ok ? `PF_RESP_OKAY : `PF_RESP_DECERR;
		end else if (r_hs) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// helper: cycles the switches have stood closed
	logic [`PF_CNT_W-1:0] closed_run_ff;
	always_ff @(posedge aclk) begin
		if (!aresetn || !all_closed) begin
			closed_run_ff <= '0;
		end else if (closed_run_ff != '1) begin
			closed_run_ff <= closed_run_ff + `PF_CNT_W'(1);
		end
	end

	chk_data_open: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(ch_busy[`PF_CH_DATA]) |=> (pass_sw == pass_sw_t'('0)))
		else $error("data fault did not open switches");
	chk_cc_open: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(ch_busy[`PF_CH_CC]) |=> (pass_sw == pass_sw_t'('0)))
		else $error("cc fault did not open switches");
	chk_fault_assert: assert property (@(posedge aclk) disable iff (!aresetn)
		rep_busy |=> !fault_n)
		else $error("reported fault not asserted");
	chk_busy_open: assert property (@(posedge aclk) disable iff (!aresetn)
		any_busy |=> (pass_sw == pass_sw_t'('0)) && !all_closed)
		else $error("switches closed during fault");
	chk_release_delay: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(fault_n) |-> $past(closed_run_ff) >= `PF_CNT_W'(DEASSERT_CYC - 1))
		else $error("fault released too soon");
	chk_ground_switch_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		ch_busy[`PF_CH_SG] |=> !ground_switch_gate)
		else $error("gate high during ground short");
	chk_gate_other: assert property (@(posedge aclk) disable iff (!aresetn)
		!ch_busy[`PF_CH_SG] |=> ground_switch_gate)
		else $error("gate low without ground short");
	chk_supply_off: assert property (@(posedge aclk) disable iff (!aresetn)
		!cmp_s.supply_ok |=> (pass_sw == pass_sw_t'('0)))
		else $error("switches closed without supply");
	chk_mask_high: assert property (@(posedge aclk) disable iff (!aresetn)
		(mask_s == `PF_MASK_HIGH && fault_n && !(|(ch_busy & `PF_REP_NO_OV))) |=> fault_n)
		else $error("suppressed overvoltage reported");
endmodule

// File: sim/cable_model.sv
// connector and cable model that drives comparator levels and the mask strap
`timescale 1ns/1ps
module cable_model
	import port_fault_pkg::*;
(
	// clock
	input wire logic aclk,
	// levels requested by the bench
	input wire cmp_in_t want,
	input wire logic [1:0] want_mask,
	// pins toward the sequencer
	output cmp_in_t cmp_raw,
	output logic [1:0] fault_mask_select
);
	// levels move only on the clock edge, so the synchroniser never sees a race
	always @(posedge aclk) begin
		cmp_raw <= want;
		fault_mask_select <= want_mask;
	end
endmodule

// File: sim/testbench.sv
// self-checking bench for the port fault sequencer
`timescale 1ns/1ps
`include "port_fault_map.svh"
module testbench;
	import port_fault_pkg::*;
	// short time must outlast the trip checks plus the hold, so a short fault stays short
	localparam int SHORT_C = 12;
	localparam int SG_BIT = 3;
	localparam int LONG_C = 16;
	localparam int DEAS_C = 4;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic s_axi_awvalid = 1'h0;
	logic s_axi_wvalid = 1'h0;
	logic s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0;
	logic s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	cmp_in_t want = '0;
	cmp_in_t cmp_raw;
	logic [1:0] want_mask = 2'h0;
	logic [1:0] fault_mask_select;
	pass_sw_t pass_sw;
	logic fault_n, ground_switch_gate, ground_short_flag;
	int errors = 0;
	int checks = 0;

	always #5 aclk = ~aclk;

	cable_model cable_u (.aclk(aclk), .want(want), .want_mask(want_mask), .cmp_raw(cmp_raw),
		.fault_mask_select(fault_mask_select));

	port_fault_sequencer #(.DATA_SHORT_CYC(SHORT_C), .DATA_LONG_CYC(LONG_C),
		.CC_SHORT_CYC(SHORT_C), .CC_LONG_CYC(LONG_C), .SG_SHORT_CYC(SHORT_C),
		.SG_LONG_CYC(LONG_C), .OT_REC_CYC(SHORT_C), .BV_REC_CYC(SHORT_C),
		.DEASSERT_CYC(DEAS_C)) dut_u (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.cmp_raw(cmp_raw), .fault_mask_select(fault_mask_select), .pass_sw(pass_sw),
		.fault_n(fault_n), .ground_switch_gate(ground_switch_gate),
		.ground_short_flag(ground_short_flag));

	task automatic give_verdict();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic timed_out(input string what);
		errors++;
		$display("Error at %0t: timeout on %s", $time, what);
		give_verdict();
	endtask

	task automatic end_test(input string what);
		$display("test %s done", what);
	endtask

	// bounded wait until every pass switch reads closed; n counts the cycles taken
	task automatic wait_closed(output int n);
		n = 0;
		do begin
			@(negedge aclk);
			n++;
		end while (pass_sw !== 5'h1F && n < 200);
		if (n >= 200) timed_out("switch close");
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
			if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1 && n < 50);
		if (n >= 50) timed_out("write");
		s_axi_bready <= 1'h0;
		chk(s_axi_bresp, r, "bresp");
	endtask

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1 && n < 50);
		if (n >= 50) timed_out("read");
		s_axi_rready <= 1'h0;
		chk(s_axi_rdata, d, "rdata");
		chk(s_axi_rresp, r, "rresp");
	endtask

	// one fault on comparator bit idx, held hold cycles past the trip check
	task automatic run_fault(input int idx, input int hold, input logic rep);
		int n;
		@(posedge aclk);
		want[idx] <= 1'h1;
		repeat (7) @(negedge aclk);
		chk(pass_sw, 5'h00, "trip open");
		chk(fault_n, !rep, "trip fault");
		chk(ground_switch_gate, idx != SG_BIT, "trip gate");
		chk(ground_short_flag, idx == SG_BIT, "trip flag");
		repeat (hold) @(negedge aclk);
		chk(pass_sw, 5'h00, "held open");
		@(posedge aclk);
		want[idx] <= 1'h0;
		wait_closed(n);
		if (hold > SHORT_C) begin
			chk(n >= LONG_C, 1'h1, "long recovery");
		end else begin
			chk(n <= SHORT_C, 1'h1, "short recovery");
		end
		chk(fault_n, !rep, "fault after close");
		chk(ground_switch_gate, 1'h1, "gate after close");
		repeat (DEAS_C + 2) @(negedge aclk);
		chk(fault_n, 1'h1, "fault released");
	endtask

	initial begin
		int n;
		repeat (4) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (10) @(negedge aclk);
		chk(pass_sw, 5'h00, "no supply open");
		chk(fault_n, 1'h1, "no supply fault");
		chk(ground_switch_gate, 1'h1, "no supply gate");
		@(posedge aclk);
		want.supply_ok <= 1'h1;
		wait_closed(n);
		end_test("reset");
		// every source under every strap setting; hidden faults still open the switches
		for (int m = 0; m < 4; m++) begin
			@(posedge aclk);
			want_mask <= m[1:0];
			for (int i = 0; i < 6; i++) begin
				run_fault(i, 2, !((m == 1 && i == 5) || (m == 2 && i < 3)));
			end
		end
		end_test("short faults per strap");
		@(posedge aclk);
		want_mask <= 2'h0;
		for (int i = 0; i < 4; i++) begin
			run_fault(i, 20, 1'h1);
		end
		end_test("persistent faults");
		@(posedge aclk);
		want.data_ov <= 1'h1;
		repeat (3) @(posedge aclk);
		want.connector_cfg_line1_ov <= 1'h1;
		want.data_ov <= 1'h0;
		repeat (20) @(negedge aclk);
		chk(pass_sw, 5'h00, "overlap open");
		chk(fault_n, 1'h0, "overlap fault");
		@(posedge aclk);
		want.connector_cfg_line1_ov <= 1'h0;
		wait_closed(n);
		chk(n >= LONG_C, 1'h1, "overlap recovery");
		repeat (DEAS_C + 2) @(negedge aclk);
		chk(fault_n, 1'h1, "overlap released");
		end_test("overlap");
		axi_rd(`PF_OFS_SEEN, 32'h0000001F, `PF_RESP_OKAY);
		axi_wr(`PF_OFS_SEEN, 32'h0000001F, `PF_RESP_OKAY);
		axi_rd(`PF_OFS_SEEN, 32'h00000000, `PF_RESP_OKAY);
		axi_rd(`PF_OFS_STATUS, 32'h00004500, `PF_RESP_OKAY);
		axi_wr(`PF_OFS_STATUS, 32'hFFFFFFFF, `PF_RESP_OKAY);
		axi_rd(`PF_OFS_STATUS, 32'h00004500, `PF_RESP_OKAY);
		axi_wr(`PF_OFS_CTRL, 32'h00000001, `PF_RESP_OKAY);
		repeat (4) @(negedge aclk);
		chk(pass_sw, 5'h00, "forced open");
		axi_rd(`PF_OFS_CTRL, 32'h00000001, `PF_RESP_OKAY);
		axi_wr(`PF_OFS_CTRL, 32'h00000000, `PF_RESP_OKAY);
		wait_closed(n);
		axi_rd(8'h0C, 32'h00000000, `PF_RESP_DECERR);
		axi_wr(8'h0C, 32'h00000001, `PF_RESP_DECERR);
		end_test("registers");
		give_verdict();
	end
endmodule
